//--- design/tko_pkg.sv
// Constants and types shared by the touch key output control block
package tko_pkg;
	localparam int unsigned TKO_CLK_HZ = 25000000;
	localparam int unsigned TKO_CLK_PERIOD_NS = 40;
	// Longest continuous press before forced return to power-on state
	localparam int unsigned TKO_MAX_PRESS_S = 75;
	localparam longint unsigned TKO_MAX_PRESS_CYC = longint'(TKO_MAX_PRESS_S) * TKO_CLK_HZ;
	// Response and release delays; values are plain defaults
	localparam int unsigned TKO_RESP_DELAY_US = 60000;
	localparam int unsigned TKO_REL_DELAY_US = 60000;
	localparam int unsigned TKO_RESP_DELAY_CYC = (TKO_RESP_DELAY_US * 1000) / TKO_CLK_PERIOD_NS;
	localparam int unsigned TKO_REL_DELAY_CYC = (TKO_REL_DELAY_US * 1000) / TKO_CLK_PERIOD_NS;
	localparam logic TKO_MODE_SYNC = 1'h0;
	localparam logic TKO_MODE_HOLD = 1'h1;
	localparam logic TKO_POL_HIGH = 1'h0;
	localparam logic TKO_POL_LOW = 1'h1;
	localparam logic TKO_RST_OUT_ACTIVE = 1'h0;
	localparam logic TKO_RST_LATCH = 1'h0;
	typedef enum logic [1:0] {
		TKO_IDLE = 2'h0,
		TKO_PRESSED = 2'h1,
		TKO_LOCKOUT = 2'h3
	} tko_state_t;
endpackage

//--- design/tko_debounce_if.sv
// Interface between debouncer and output control
`timescale 1ns/10ps
`default_nettype none
interface tko_debounce_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

//--- design/tko_debounce.sv
// Touch input debouncer with separate assert and release counts
`timescale 1ns/10ps
`default_nettype none
module tko_debounce
	import tko_pkg::*;
#(
	parameter int unsigned RESP_CYC = TKO_RESP_DELAY_CYC,
	parameter int unsigned REL_CYC = TKO_REL_DELAY_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic raw,
	tko_debounce_if.src dbo
);
	localparam int unsigned CW = $clog2((RESP_CYC > REL_CYC ? RESP_CYC : REL_CYC) + 1);
	initial begin
		if (RESP_CYC < 1 || REL_CYC < 1) begin
			$error("Debounce counts must be at least one");
		end
	end
	logic level;
	logic next_level;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic rise;
	logic next_rise;
	logic fall;
	logic next_fall;
	// R10 R12 Persistence filter
	always_comb begin
		next_level = level;
		next_cnt = '0;
		next_rise = 1'h0;
		next_fall = 1'h0;
		if (raw != level) begin
			next_cnt = cnt + CW'(1);
			if (!level && next_cnt >= CW'(RESP_CYC)) begin
				next_level = 1'h1;
				next_rise = 1'h1;
				next_cnt = '0;
			end else if (level && next_cnt >= CW'(REL_CYC)) begin
				next_level = 1'h0;
				next_fall = 1'h1;
				next_cnt = '0;
			end
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level <= 1'h0;
			cnt <= '0;
			rise <= 1'h0;
			fall <= 1'h0;
		end else begin
			level <= next_level;
			cnt <= next_cnt;
			rise <= next_rise;
			fall <= next_fall;
		end
	end
	assign dbo.level = level;
	assign dbo.rise = rise;
	assign dbo.fall = fall;
endmodule
`default_nettype wire

//--- design/tko_top.sv
// Touch key output control: modes, polarity, press timeout
`timescale 1ns/10ps
`default_nettype none
// Contract
// R01 - Sync mode: output active while touched
// R02 - Sync mode: inactive when touch ends
// R03 - Hold mode: touch latches output active
// R04 - Hold mode: next touch clears output
// R05 - Polarity strap high inverts output level
// R06 - Floating mode strap reads sync mode
// R07 - Floating polarity strap reads active high
// R08 - 75 s press forces power-on state
// R09 - After timeout, wait for fresh touch
// R10 - Debounce touch input against noise
// R11 - Board ties default straps to fixed level
// R12 - Response and release delays are counts
// R13 - Reset clears latch, timer, output inactive; code drives key_out low in reset for either polarity
module tko_top
	import tko_pkg::*;
#(
	parameter longint unsigned MAX_PRESS_CYC = TKO_MAX_PRESS_CYC,
	parameter int unsigned RESP_CYC = TKO_RESP_DELAY_CYC,
	parameter int unsigned REL_CYC = TKO_REL_DELAY_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic touch_pad_input,
	input wire logic hold_mode_select,
	input wire logic output_polarity_select,
	output logic key_out
);
	localparam int unsigned TW = $clog2(MAX_PRESS_CYC + 1);
	initial begin
		if (MAX_PRESS_CYC < 2) begin
			$error("Press timeout too short");
		end
	end
	// Two-stage synchronisers on all three pins
	logic [2:0] sync1;
	logic [2:0] sync2;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else begin
			sync1 <= {output_polarity_select, hold_mode_select, touch_pad_input};
			sync2 <= sync1;
		end
	end
	// R06 R07 Pull-down modeled as reset value low
	logic mode;
	logic pol;
	assign mode = sync2[1];
	assign pol = sync2[2];
	tko_debounce_if dbi ();
	tko_debounce #(
		.RESP_CYC(RESP_CYC),
		.REL_CYC(REL_CYC)
	) u_deb (
		.clk_sys(clk_sys),
		.rst(rst),
		.raw(sync2[0]),
		.dbo(dbi.src)
	);
	tko_state_t state;
	tko_state_t next_state;
	logic latch;
	logic next_latch;
	logic [TW-1:0] timer;
	logic [TW-1:0] next_timer;
	logic active;
	logic next_key_out;
	always_comb begin
		next_state = state;
		next_latch = latch;
		next_timer = '0;
		unique case (state)
			TKO_IDLE: begin
				if (dbi.rise) begin
					next_state = TKO_PRESSED;
					// R03 R04 Toggle on each recognised touch
					next_latch = ~latch;
				end
			end
			TKO_PRESSED: begin
				next_timer = timer + TW'(1);
				if (dbi.fall || !dbi.level) begin
					next_state = TKO_IDLE;
				end else if (next_timer >= TW'(MAX_PRESS_CYC)) begin
					// R08 Timeout restores power-on state
					next_state = TKO_LOCKOUT;
					next_latch = TKO_RST_LATCH;
					next_timer = '0;
				end
			end
			TKO_LOCKOUT: begin
				// R09 Ignore stuck touch until released
				if (!dbi.level) begin
					next_state = TKO_IDLE;
				end
			end
			default: begin
				next_state = TKO_IDLE;
				next_latch = TKO_RST_LATCH;
			end
		endcase
	end
	always_comb begin
		if (mode == TKO_MODE_HOLD) begin
			active = next_latch;
		end else begin
			// R01 R02 Output follows debounced touch
			active = (next_state == TKO_PRESSED);
		end
		// R05 Polarity applied at the output flop
		next_key_out = active ^ (pol == TKO_POL_LOW);
	end
	// R13 Reset clears latch, timer and output
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= TKO_IDLE;
			latch <= TKO_RST_LATCH;
			timer <= '0;
			key_out <= TKO_RST_OUT_ACTIVE;
		end else begin
			state <= next_state;
			latch <= next_latch;
			timer <= next_timer;
			key_out <= next_key_out;
		end
	end
endmodule
`default_nettype wire

//--- verif/tko_pad.sv
// Touch pad model driving the key input
`timescale 1ns/10ps
`default_nettype none
module tko_pad (
	input wire logic clk_sys,
	output logic touch_pad_input = 1'h0
);
	// Released pad reads low; level held n cycles
	task automatic hold(input logic v, input int n);
		@(negedge clk_sys) touch_pad_input = v;
		repeat (n - 1) @(negedge clk_sys);
	endtask
endmodule
`default_nettype wire

//--- verif/tko_chk.sv
// Checker on the key output pins
`timescale 1ns/10ps
`default_nettype none
module tko_chk import tko_pkg::*;
#(parameter longint unsigned MAX_PRESS_CYC = TKO_MAX_PRESS_CYC) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic touch_pad_input,
	input wire logic hold_mode_select,
	input wire logic output_polarity_select,
	input wire logic key_out
);
	logic [15:0] hc;
	wire t = touch_pad_input;
	wire m = hold_mode_select;
	wire a = key_out ^ output_polarity_select;
	always_ff @(posedge clk_sys or posedge rst)
		if (rst) hc <= 16'h0;
		else hc <= t ? hc + {15'h0, ~&hc} : 16'h0;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_rst; disable iff (1'h0) rst |-> !key_out; endproperty
	property p_idl; $fell(rst) |-> ##4 !a; endproperty
	property p_on; !m && $rose(t) ##1 t[*8] |-> ##3 a; endproperty
	property p_off; !m && $fell(t) ##1 !t[*8] |-> ##3 !a; endproperty
	property p_kp; m && $rose(a) |=> a[*8]; endproperty
	property p_tg; m && $rose(t) ##1 t[*8] |-> ##3 a != $past(a, 12); endproperty
	property p_ns; $rose(t) ##1 !t |=> $stable(a)[*8]; endproperty
	// Margin allows for debounce ahead of timer
	property p_tm; hc >= MAX_PRESS_CYC + 40 |-> !a; endproperty
	a_rst: assert property (p_rst) else $error("reset level");
	a_idl: assert property (p_idl) else $error("idle level");
	a_on: assert property (p_on) else $error("sync on");
	a_off: assert property (p_off) else $error("sync off");
	a_kp: assert property (p_kp) else $error("hold lost");
	a_tg: assert property (p_tg) else $error("no toggle");
	a_ns: assert property (p_ns) else $error("noise");
	a_tm: assert property (p_tm) else $error("timeout");
	cover property (m && $rose(a));
	cover property (!m && $fell(a));
	cover property (hc == 16'hff);
endmodule
bind tko_top tko_chk #(.MAX_PRESS_CYC(MAX_PRESS_CYC)) i_tko_chk (.*);
`default_nettype wire

//--- verif/tb_tko_top.sv
// Bench for the touch key output control
`timescale 1ns/10ps
`default_nettype none
module tb_tko_top;
	logic clk_sys = 1'h0, rst = 1'h1, hold_mode_select = 1'h0, output_polarity_select = 1'h0;
	wire touch_pad_input, key_out;
	int mismatches = 0, cmp_count = 0;
	// Short counts keep the run brief
	tko_top #(.MAX_PRESS_CYC(200), .RESP_CYC(4), .REL_CYC(4)) i_tko_top (
		.clk_sys(clk_sys),
		.rst(rst),
		.touch_pad_input(touch_pad_input),
		.hold_mode_select(hold_mode_select),
		.output_polarity_select(output_polarity_select),
		.key_out(key_out)
	);
	tko_pad i_tko_pad (.clk_sys(clk_sys), .touch_pad_input(touch_pad_input));
	initial forever #20 clk_sys = ~clk_sys;
	task automatic step(input logic v, input int n, input logic e);
		i_tko_pad.hold(v, n);
		cmp_count++;
		if (key_out !== (e ^ output_polarity_select)) begin
			mismatches++;
			$display("MISMATCH key_out exp %b got %b", e ^ output_polarity_select, key_out);
		end
	endtask
	task automatic cfg(input logic m, input logic p);
		@(negedge clk_sys);
		{hold_mode_select, output_polarity_select, rst} = {m, p, 1'h1};
		repeat (12) @(negedge clk_sys);
		rst = 1'h0;
		step(1'h0, 8, 1'h0);
	endtask
	task automatic t_sync(input logic p);
		cfg(1'h0, p);
		step(1'h1, 20, 1'h1);
		step(1'h0, 20, 1'h0);
		$display("sync done");
	endtask
	task automatic t_hold(input logic p);
		cfg(1'h1, p);
		i_tko_pad.hold(1'h1, 20);
		step(1'h0, 20, 1'h1);
		step(1'h1, 20, 1'h0);
		step(1'h0, 20, 1'h0);
		$display("hold done");
	endtask
	// Hold mode so a false press would latch
	task automatic t_noise;
		cfg(1'h1, 1'h0);
		i_tko_pad.hold(1'h1, 1);
		i_tko_pad.hold(1'h0, 3);
		i_tko_pad.hold(1'h1, 3);
		step(1'h0, 20, 1'h0);
		$display("noise done");
	endtask
	task automatic t_tmo;
		cfg(1'h1, 1'h1);
		step(1'h1, 150, 1'h1);
		step(1'h1, 110, 1'h0);
		i_tko_pad.hold(1'h0, 20);
		step(1'h1, 20, 1'h1);
		$display("timeout done");
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		t_sync(1'h0);
		t_sync(1'h1);
		t_hold(1'h0);
		t_hold(1'h1);
		t_noise;
		t_tmo;
		finish_test;
	end
	// Tests take about 700 cycles
	initial begin
		#200000;
		mismatches++;
		finish_test;
	end
endmodule
`default_nettype wire
